/* verilog/awd_pkg.sv */
package awd_pkg;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFF_SECTOR_COUNT = 8'h00;
    localparam logic [7:0] OFF_SECTOR_NUMBER = 8'h04;
    localparam logic [7:0] OFF_CYLINDER_LOW = 8'h08;
    localparam logic [7:0] OFF_CYLINDER_HIGH = 8'h0c;
    localparam logic [7:0] OFF_DRIVE_SELECT = 8'h10;
    localparam logic [7:0] OFF_COMMAND_STATUS = 8'h14;
    localparam logic [7:0] OFF_ERROR = 8'h18;
    localparam logic [7:0] OFF_DEVICE_CONTROL = 8'h1c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h24;

    // ----------------------------------------
    // opcodes
    // ----------------------------------------
    localparam logic [7:0] OPC_WRITE_DMA = 8'hca;
    localparam logic [7:0] OPC_WRITE_DMA_FUA_EXT = 8'h3d;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int DRV_LBA_BIT = 6;
    localparam int CTL_HOB_BIT = 7;
    localparam int ERR_CRC_BIT = 7;
    localparam int ERR_IDN_BIT = 4;
    localparam int ERR_ABT_BIT = 2;
    localparam int ST_BSY_BIT = 7;
    localparam int ST_RDY_BIT = 6;
    localparam int ST_DF_BIT = 5;
    localparam int ST_DSC_BIT = 4;
    localparam int ST_DRQ_BIT = 3;
    localparam int ST_ERR_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_FAIL_BIT = 1;
    localparam int IRQ_W = 2;

    // ----------------------------------------
    // sizes and reset values
    // ----------------------------------------
    localparam int WORDS_PER_SECTOR = 256;
    localparam int COUNT28_ZERO = 256;
    localparam int COUNT48_ZERO = 65536;
    localparam int CHS_FIRST_SECTOR = 1;
    localparam logic [7:0] DRV_RESET = 8'ha0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        AWD_IDLE,
        AWD_XFER,
        AWD_MEDIA,
        AWD_FLUSH,
        AWD_DONE
    } awd_fsm_t;

    // toward the media write path
    typedef struct packed {
        logic [15:0] word;
        logic word_valid;
        logic sector_end;
        logic [47:0] addr;
        logic flush_req;
    } awd_media_out_t;

    // answers from the media write path
    typedef struct packed {
        logic sector_done;
        logic sector_fail;
        logic flush_done;
    } awd_media_in_t;

endpackage

/* verilog/awd_write_dma.sv */
`timescale 1ns/100ps
// Operation
// R1: both 28-bit opcodes accepted, retry bit ignored
// R2: 8-bit count, zero means 256
// R3: sector number or address bits 0-7
// R4: cylinder pair or address bits 8-23
// R5: head field or address bits 24-27
// R6: payload moves as 16-bit words
// R7: host arms DMA before writing command
// R8: transfers only while DMA request asserted
// R9: one interrupt per command, after status
// R10: stop at failing sector
// R11: count register returns sectors not transferred
// R12: address registers return last transferred sector
// R13: head field returns last sector head
// R14: forced-access write commits before ending status
// R15: 16-bit count from current and previous
// R16: 48-bit count zero means 65536
// R17: 48-bit address from current and previous
// R18: 48-bit failure reports first error address
// R19: ending status and error bit set
module awd_write_dma #(
    parameter int SECTORS_PER_TRACK = 63,
    parameter int HEADS = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic dma_req,
    input wire logic dma_ack,
    input wire logic [15:0] dma_data,
    input wire logic crc_error,
    output awd_pkg::awd_media_out_t media_out,
    input wire awd_pkg::awd_media_in_t media_in
);
    import awd_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        awd_fsm_t fsm;
        logic [7:0] sc_cur;
        logic [7:0] sc_prev;
        logic [7:0] sn_cur;
        logic [7:0] sn_prev;
        logic [7:0] cl_cur;
        logic [7:0] cl_prev;
        logic [7:0] ch_cur;
        logic [7:0] ch_prev;
        logic [7:0] drv;
        logic [7:0] err;
        logic high_order_byte_select;
        logic is48;
        logic lba_mode;
        logic failed;
        logic [47:0] addr;
        logic [47:0] last;
        logic [16:0] remain;
        logic [7:0] word_cnt;
        logic ack_meta;
        logic ack_sync;
        logic ack_prev;
        logic [15:0] dat_meta;
        logic [15:0] dat_sync;
        awd_media_out_t mo;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
    } awd_state_t;

    localparam logic [7:0] WORD_LAST = 8'(WORDS_PER_SECTOR - 1);
    localparam logic [16:0] CNT28_ZERO = 17'(COUNT28_ZERO);
    localparam logic [16:0] CNT48_ZERO = 17'(COUNT48_ZERO);
    localparam logic [7:0] SPT = 8'(SECTORS_PER_TRACK);
    localparam logic [3:0] HEAD_LAST = 4'(HEADS - 1);
    localparam logic [7:0] FIRST_SEC = 8'(CHS_FIRST_SECTOR);

    awd_state_t state_reg;
    awd_state_t state_next;

    logic setup;
    logic wr_access;
    logic ack_rise;
    logic [7:0] status;
    logic [7:0] ctl_byte;

    // next address: block mode counts up, chs walks sector, head, cylinder
    function automatic logic [47:0] next_addr(input logic [47:0] a, input logic lba);
        logic [47:0] n;
        n = a;
        if (lba)
            n = a + 48'h1;
        else if (a[7:0] < SPT)
            n[7:0] = a[7:0] + 8'h1;
        else
        begin
            n[7:0] = FIRST_SEC;
            if (a[27:24] < HEAD_LAST)
                n[27:24] = a[27:24] + 4'h1;
            else
            begin
                n[27:24] = 4'h0;
                n[23:8] = a[23:8] + 16'h1;
            end
        end
        return n;
    endfunction

    // ----------------------------------------
    // bus and status decode
    // ----------------------------------------
    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign ack_rise = state_reg.ack_sync && !state_reg.ack_prev;

    always_comb
    begin
        status = 8'h00;
        status[ST_BSY_BIT] = (state_reg.fsm != AWD_IDLE);
        status[ST_RDY_BIT] = 1'b1; // see R19
        status[ST_DF_BIT] = 1'b0; // see R19
        status[ST_DSC_BIT] = 1'b1; // see R19
        status[ST_DRQ_BIT] = (state_reg.fsm == AWD_XFER);
        status[ST_ERR_BIT] = (state_reg.err != 8'h00); // see R19
        ctl_byte = 8'h00;
        ctl_byte[CTL_HOB_BIT] = state_reg.high_order_byte_select;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        logic idle;
        logic [16:0] cnt;
        logic [7:0] opc;
        logic fail_now;
        logic [IRQ_W-1:0] ev;
        idle = 1'b0;
        cnt = 17'h0;
        opc = 8'h00;
        fail_now = 1'b0;
        ev = '0;
        state_next = state_reg;
        idle = (state_reg.fsm == AWD_IDLE);

        // pin synchronisers
        state_next.ack_meta = dma_ack;
        state_next.ack_sync = state_reg.ack_meta;
        state_next.ack_prev = state_reg.ack_sync;
        state_next.dat_meta = dma_data;
        state_next.dat_sync = state_reg.dat_meta;
        state_next.mo.word_valid = 1'b0;
        state_next.mo.sector_end = 1'b0;

        // read data is registered in the setup phase
        if (setup && !pwrite)
        begin
            state_next.rdata = RDATA_RESET;
            unique case (paddr)
                OFF_SECTOR_COUNT: state_next.rdata[7:0] =
                    state_reg.high_order_byte_select ? state_reg.sc_prev : state_reg.sc_cur;
                OFF_SECTOR_NUMBER: state_next.rdata[7:0] =
                    state_reg.high_order_byte_select ? state_reg.sn_prev : state_reg.sn_cur; // see R18
                OFF_CYLINDER_LOW: state_next.rdata[7:0] =
                    state_reg.high_order_byte_select ? state_reg.cl_prev : state_reg.cl_cur; // see R18
                OFF_CYLINDER_HIGH: state_next.rdata[7:0] =
                    state_reg.high_order_byte_select ? state_reg.ch_prev : state_reg.ch_cur; // see R18
                OFF_DRIVE_SELECT: state_next.rdata[7:0] = state_reg.drv;
                OFF_COMMAND_STATUS: state_next.rdata[7:0] = status;
                OFF_ERROR: state_next.rdata[7:0] = state_reg.err;
                OFF_DEVICE_CONTROL: state_next.rdata[7:0] = ctl_byte;
                OFF_IRQ_STATUS: state_next.rdata[IRQ_W-1:0] = state_reg.irq_stat;
                OFF_IRQ_MASK: state_next.rdata[IRQ_W-1:0] = state_reg.irq_mask;
                default: state_next.rdata = RDATA_RESET;
            endcase
        end

        // writes take effect at the access edge; task file is locked while busy
        if (wr_access)
        begin
            unique case (paddr)
                OFF_SECTOR_COUNT:
                if (idle)
                begin
                    state_next.sc_prev = state_reg.sc_cur;
                    state_next.sc_cur = pwdata[7:0];
                end
                OFF_SECTOR_NUMBER:
                if (idle)
                begin
                    state_next.sn_prev = state_reg.sn_cur;
                    state_next.sn_cur = pwdata[7:0];
                end
                OFF_CYLINDER_LOW:
                if (idle)
                begin
                    state_next.cl_prev = state_reg.cl_cur;
                    state_next.cl_cur = pwdata[7:0];
                end
                OFF_CYLINDER_HIGH:
                if (idle)
                begin
                    state_next.ch_prev = state_reg.ch_cur;
                    state_next.ch_cur = pwdata[7:0];
                end
                OFF_DRIVE_SELECT:
                if (idle)
                    state_next.drv = pwdata[7:0];
                OFF_DEVICE_CONTROL: state_next.high_order_byte_select = pwdata[CTL_HOB_BIT];
                OFF_IRQ_MASK: state_next.irq_mask = pwdata[IRQ_W-1:0];
                OFF_COMMAND_STATUS:
                if (idle)
                    opc = pwdata[7:0];
                default: ;
            endcase
        end

        unique case (state_reg.fsm)
            AWD_IDLE:
            if (opc != 8'h00)
            begin
                state_next.err = 8'h00;
                state_next.failed = 1'b0;
                state_next.word_cnt = 8'h00;
                state_next.high_order_byte_select = 1'b0;
                if (opc[7:1] == OPC_WRITE_DMA[7:1]) // see R1
                begin
                    state_next.is48 = 1'b0;
                    state_next.lba_mode = state_reg.drv[DRV_LBA_BIT];
                    cnt = {9'h0, state_reg.sc_cur};
                    state_next.remain = (cnt == 17'h0) ? CNT28_ZERO : cnt; // see R2
                    state_next.addr = {20'h0, state_reg.drv[3:0], // see R5
                        state_reg.ch_cur, state_reg.cl_cur, // see R4
                        state_reg.sn_cur}; // see R3
                    state_next.fsm = AWD_XFER;
                end
                else if (opc == OPC_WRITE_DMA_FUA_EXT)
                begin
                    state_next.is48 = 1'b1;
                    state_next.lba_mode = 1'b1;
                    cnt = {1'b0, state_reg.sc_prev, state_reg.sc_cur}; // see R15
                    state_next.remain = (cnt == 17'h0) ? CNT48_ZERO : cnt; // see R16
                    state_next.addr = {state_reg.ch_prev, state_reg.cl_prev, // see R17
                        state_reg.sn_prev, state_reg.ch_cur,
                        state_reg.cl_cur, state_reg.sn_cur};
                    state_next.fsm = AWD_XFER;
                end
                else
                begin
                    state_next.err[ERR_ABT_BIT] = 1'b1; // see R19
                    state_next.fsm = AWD_DONE;
                end
                state_next.last = state_next.addr;
                state_next.mo.addr = state_next.addr;
            end
            AWD_XFER:
            // dma_req only high here; host moves a word per ack while it stands
            if (ack_rise) // see R8
            begin
                state_next.mo.word = state_reg.dat_sync; // see R6
                state_next.mo.word_valid = 1'b1;
                state_next.word_cnt = state_reg.word_cnt + 8'h1;
                if (state_reg.word_cnt == WORD_LAST)
                begin
                    state_next.mo.sector_end = 1'b1;
                    state_next.fsm = AWD_MEDIA;
                end
            end
            AWD_MEDIA:
            if (media_in.sector_done)
            begin
                fail_now = media_in.sector_fail;
                if (fail_now)
                begin
                    // first failing sector ends the command
                    state_next.err[ERR_IDN_BIT] = 1'b1; // see R10
                    state_next.failed = 1'b1;
                    if (state_reg.is48)
                        state_next.last = state_reg.addr; // see R18
                    state_next.fsm = AWD_DONE;
                end
                else
                begin
                    state_next.last = state_reg.addr;
                    state_next.remain = state_reg.remain - 17'h1;
                    state_next.addr = next_addr(state_reg.addr, state_reg.lba_mode);
                    state_next.mo.addr = state_next.addr;
                    if (state_reg.remain == 17'h1)
                        state_next.fsm = state_reg.is48 ? AWD_FLUSH : AWD_DONE; // see R14
                    else
                        state_next.fsm = AWD_XFER;
                end
            end
            AWD_FLUSH:
            // ending status held back until the media confirms the commit
            if (media_in.flush_done) // see R14
                state_next.fsm = AWD_DONE;
            AWD_DONE:
            begin
                // write back progress registers and raise one interrupt in the same cycle
                state_next.sc_cur = state_reg.remain[7:0]; // see R11
                state_next.sc_prev = state_reg.remain[15:8];
                state_next.sn_cur = state_reg.last[7:0]; // see R12
                state_next.cl_cur = state_reg.last[15:8]; // see R12
                state_next.ch_cur = state_reg.last[23:16]; // see R12
                if (state_reg.is48)
                begin
                    state_next.sn_prev = state_reg.last[31:24]; // see R18
                    state_next.cl_prev = state_reg.last[39:32];
                    state_next.ch_prev = state_reg.last[47:40];
                end
                else
                    state_next.drv[3:0] = state_reg.last[27:24]; // see R13
                ev[IRQ_DONE_BIT] = 1'b1; // see R9
                ev[IRQ_FAIL_BIT] = state_reg.failed || (state_reg.err != 8'h00);
                state_next.fsm = AWD_IDLE;
            end
            default: state_next.fsm = AWD_IDLE;
        endcase

        // link crc errors seen during transfer are reported at the end
        if (crc_error && state_reg.fsm == AWD_XFER)
            state_next.err[ERR_CRC_BIT] = 1'b1; // see R19

        state_next.mo.flush_req = (state_next.fsm == AWD_FLUSH);

        // sticky events: a new event beats a same-cycle clear
        if (wr_access && paddr == OFF_IRQ_STATUS)
            state_next.irq_stat = state_reg.irq_stat & ~pwdata[IRQ_W-1:0];
        state_next.irq_stat = state_next.irq_stat | ev;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= '0;
            state_reg.fsm <= AWD_IDLE;
            state_reg.drv <= DRV_RESET;
        end
        else
            state_reg <= state_next;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata = state_reg.rdata;
    assign dma_req = (state_reg.fsm == AWD_XFER); // see R8
    assign irq = |(state_reg.irq_stat & state_reg.irq_mask); // see R9
    assign media_out = state_reg.mo;

endmodule

/* dv/awd_write_dma_asserts.sv */
`timescale 1ns/100ps
module awd_write_dma_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic irq,
    input wire logic dma_req,
    input wire logic dma_ack,
    input wire logic [15:0] dma_data,
    input wire awd_pkg::awd_media_out_t media_out,
    input wire awd_pkg::awd_media_in_t media_in
);
    import awd_pkg::*;
    logic kick;
    // a request may only follow a command write or a sector answer
    assign kick = (psel && penable && pwrite && paddr == OFF_COMMAND_STATUS)
        || media_in.sector_done;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ------------------------------
    // assertions
    // ------------------------------
    a_word_has_ack: assert property (media_out.word_valid |-> $past(dma_ack, 3))
        else $error("word taken without an ack");
    a_word_is_data: assert property (
        media_out.word_valid |-> media_out.word == $past(dma_data, 3))
        else $error("word differs from the data bus");
    a_end_on_word: assert property (media_out.sector_end |-> media_out.word_valid)
        else $error("sector end without a word");
    a_req_drops: assert property (media_out.sector_end |-> ##[0:1] !dma_req)
        else $error("request held past sector end");
    a_req_cause: assert property ($rose(dma_req) |-> $past(kick) || $past(kick, 2))
        else $error("request raised without cause");
    a_fail_halts: assert property (
        media_in.sector_done && media_in.sector_fail |=> !dma_req [*8])
        else $error("transfer went on after a failed sector");
    a_irq_at_end: assert property (
        $rose(irq) |-> !dma_req && !media_out.flush_req)
        else $error("interrupt before the end");
    a_flush_wait: assert property (
        media_out.flush_req && !media_in.flush_done |=> media_out.flush_req && !dma_req)
        else $error("flush abandoned early");
    c_flush: cover property ($rose(media_out.flush_req));
    c_fail: cover property (media_in.sector_fail);
    c_irq: cover property ($rose(irq));
endmodule

bind awd_write_dma awd_write_dma_asserts u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .irq(irq), .dma_req(dma_req),
    .dma_ack(dma_ack), .dma_data(dma_data), .media_out(media_out), .media_in(media_in));

/* dv/awd_host_dma.sv */
`timescale 1ns/100ps
module awd_host_dma (
    input wire logic clk,
    input wire logic dma_req,
    input wire logic armed,
    input wire logic [3:0] gap,
    output logic dma_ack,
    output logic [15:0] dma_data
);
    int n;
    initial
    begin
        n = 0;
        dma_ack = 1'h0;
        dma_data = 16'hffff;
        forever
        begin
            @(posedge clk);
            if (armed && dma_req)
            begin
                dma_data <= 16'(n) ^ 16'h5a5a;
                @(posedge clk);
                dma_ack <= 1'h1;
                repeat (4) @(posedge clk);
                dma_ack <= 1'h0;
                repeat (4 + gap) @(posedge clk);
                // hold time over: show a value the device must not take
                dma_data <= ~dma_data;
                n++;
            end
        end
    end
endmodule

/* dv/awd_write_dma_test.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module awd_write_dma_test;
    import awd_pkg::*;
    logic clk = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0, armed = '0;
    logic pready, irq, dma_req, dma_ack, flushed = '0, chk_a = '0, crc_err = '0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [15:0] dma_data;
    logic [3:0] gap = '0;
    logic [47:0] exp_a = '0;
    awd_media_out_t media_out;
    awd_media_in_t media_in = '0;
    int fail_count = 0, tests_run = 0, sec_n = 0, fail_at = 0, wn = 0, fc = 0;
    always #20 clk = ~clk;
    awd_write_dma dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(), .irq(irq), .dma_req(dma_req), .dma_ack(dma_ack), .dma_data(dma_data),
        .crc_error(crc_err), .media_out(media_out), .media_in(media_in));
    awd_host_dma host (.clk(clk), .dma_req(dma_req), .armed(armed), .gap(gap),
        .dma_ack(dma_ack), .dma_data(dma_data));
    // media side: answer each sector, hold each flush a while
    always @(posedge clk)
    begin
        if (media_out.word_valid)
        begin
            `CHK("word", 16'(wn) ^ 16'h5a5a, media_out.word)
            wn++;
        end
        if (media_out.sector_end)
            sec_n++;
        if (media_out.sector_end && sec_n == 1 && chk_a)
            `CHK("addr", exp_a, media_out.addr)
        fc = (media_out.flush_req && !media_in.flush_done) ? fc + 1 : 0;
        if (fc == 12)
            flushed <= 1'h1;
        media_in <= {media_out.sector_end, media_out.sector_end && sec_n == fail_at, fc == 12};
    end
    task automatic conclude();
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int i;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'h1 && i < 16);
        r = prdata;
        if (pready !== 1'h1)
        begin
            fail_count++;
            conclude();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'h1, a, {24'h0, d}, r);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        apb(1'h0, a, 32'h0, r);
        `CHK($sformatf("reg %h", a), {24'h0, e}, r)
    endtask
    task automatic load(input logic [31:0] prev, input logic [31:0] cur, input logic [7:0] drv);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'(4 * i), prev[8 * i +: 8]);
            wr(8'(4 * i), cur[8 * i +: 8]);
        end
        wr(OFF_DRIVE_SELECT, drv);
    endtask
    task automatic chk_tf(input logic [55:0] e);
        for (int i = 0; i < 7; i++)
            rc(8'(4 * i), e[8 * i +: 8]);
    endtask
    task automatic cmd(input logic [7:0] op, input int fa, input int ns, input logic [7:0] ib);
        int i;
        fail_at = fa;
        sec_n = 0;
        armed <= 1'h1;
        wr(OFF_COMMAND_STATUS, op);
        for (i = 0; i < 30000 && irq !== 1'h1; i++)
            @(posedge clk);
        `CHK("sectors", ns, sec_n)
        if (irq !== 1'h1)
        begin
            fail_count++;
            conclude();
        end
        armed <= 1'h0;
        rc(OFF_IRQ_STATUS, ib);
        wr(OFF_IRQ_STATUS, ib);
        repeat (4) @(posedge clk);
        `CHK("irq", 1'h0, irq)
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        rc(OFF_DRIVE_SELECT, DRV_RESET);
        rc(8'h30, 8'h00);
        wr(OFF_IRQ_MASK, 8'h03);
        gap <= 4'h3;
        chk_a = 1'h1;
        exp_a = 48'h512_3456;
        load(32'h0, 32'h1234_5602, 8'he5);
        cmd(8'hcb, 0, 2, 8'h01);
        chk_tf(56'h00_50_e5_12_34_57_00);
        gap <= 4'h0;
        crc_err <= 1'h1;
        chk_a = 1'h0;
        load(32'h0, 32'h0102_3f03, 8'ha2);
        cmd(OPC_WRITE_DMA, 3, 3, 8'h03);
        chk_tf(56'h90_51_a3_01_02_01_01);
        crc_err <= 1'h0;
        chk_a = 1'h1;
        exp_a = 48'hefcd_ab03_0201;
        load(32'hefcd_ab00, 32'h0302_0101, 8'he0);
        cmd(OPC_WRITE_DMA_FUA_EXT, 0, 1, 8'h01);
        `CHK("flush", 1'h1, flushed)
        load(32'hefcd_ab00, 32'h0302_0102, 8'he0);
        cmd(OPC_WRITE_DMA_FUA_EXT, 2, 2, 8'h03);
        rc(OFF_SECTOR_COUNT, 8'h01);
        rc(OFF_CYLINDER_LOW, 8'h02);
        rc(OFF_SECTOR_NUMBER, 8'h02);
        wr(OFF_DEVICE_CONTROL, 8'h80);
        rc(OFF_CYLINDER_LOW, 8'hcd);
        rc(OFF_SECTOR_NUMBER, 8'hab);
        rc(OFF_CYLINDER_HIGH, 8'hef);
        cmd(8'h35, 0, 0, 8'h03);
        rc(OFF_ERROR, 8'h04);
        conclude();
    end
endmodule
